// ===== common/opc_pkg.sv
`default_nettype none
package opc_pkg;
   // ---------------------------------------------------------------
   // Clock rates and oscillator models
   // ---------------------------------------------------------------
   localparam longint PCLK_HZ = 10_000_000;
   localparam longint FRC_HZ = 7_370_000;
   localparam longint SLOW_HZ = 32_768;
   localparam int NCO_W = 24;
   localparam int TUNE_W = 6;
   // Phase steps per bus clock; slow model toggles, so twice its rate
   localparam logic [NCO_W-1:0] FRC_INC = NCO_W'((FRC_HZ << NCO_W) / PCLK_HZ);
   localparam logic [NCO_W-1:0] SLOW_INC = NCO_W'(((SLOW_HZ * 2) << NCO_W) / PCLK_HZ);
   // One tuning step, roughly 0.4 % of nominal
   localparam logic [NCO_W-1:0] TUNE_STEP = NCO_W'(FRC_INC >> 8);

   // ---------------------------------------------------------------
   // Register map (byte addresses) and reset values
   // ---------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam int REG_W = 16;
   localparam logic [ADDR_W-1:0] ADDR_DIV = 12'h000;
   localparam logic [ADDR_W-1:0] ADDR_FBD = 12'h004;
   localparam logic [ADDR_W-1:0] ADDR_TUNE = 12'h008;
   localparam logic [ADDR_W-1:0] ADDR_STAT = 12'h00c;
   localparam logic [REG_W-1:0] DIV_RST = 16'h0000;
   localparam logic [8:0] FBD_RST = 9'h01e;
   localparam logic [TUNE_W-1:0] TUNE_RST = 6'h00;

   // ---------------------------------------------------------------
   // Divider encodings
   // ---------------------------------------------------------------
   localparam logic [5:0] N1_OFS = 6'h02;
   localparam logic [9:0] M_OFS = 10'h002;
   localparam logic [1:0] POST_BY4 = 2'h1;
   localparam logic [1:0] POST_BY8 = 2'h3;
   localparam logic [3:0] N2_BY2 = 4'h2;
   localparam logic [3:0] N2_BY4 = 4'h4;
   localparam logic [3:0] N2_BY8 = 4'h8;
   localparam logic [2:0] FRC_DIV16_SEL = 3'h3;

   typedef enum logic [2:0] {
      SRC_FRC = 3'b000,
      SRC_FRC_PLL = 3'b001,
      SRC_PRI = 3'b010,
      SRC_PRI_PLL = 3'b011,
      SRC_SEC = 3'b100,
      SRC_SLOW = 3'b101,
      SRC_FRC_D16 = 3'b110,
      SRC_FRC_DN = 3'b111
   } opc_src_e;

   typedef enum logic [1:0] {
      PRI_EXT = 2'b00,
      PRI_XTAL = 2'b01,
      PRI_HS = 2'b10,
      PRI_NONE = 2'b11
   } opc_pri_e;

   typedef struct packed {
      logic [4:0] rsv_hi;
      logic [2:0] frc_post;
      logic [1:0] pll_post;
      logic rsv_mid;
      logic [4:0] pll_pre;
   } opc_div_s;

   typedef struct packed {
      logic [8:0] rsv;
      logic xtal_drive;
      logic pll_on;
      opc_pri_e pri;
      opc_src_e src;
   } opc_stat_s;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0] pwdata;
   } opc_apb_req_s;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } opc_apb_rsp_s;
endpackage
`default_nettype wire

// ===== logic/opc_sync.sv
`timescale 1ns/100ps
`default_nettype none
module opc_sync #(
   parameter int W = 3
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] pin,
   output logic [W-1:0] rise
);
   // ---------------------------------------------------------------
   // Two-stage synchroniser per pin, edge found after stage two
   // ---------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic meta_q;
         logic sync_q;
         logic last_q;
         // First stage feeds only the second
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               meta_q <= 1'b0;
               sync_q <= 1'b0;
               last_q <= 1'b0;
            end else begin
               meta_q <= pin[i];
               sync_q <= meta_q;
               last_q <= sync_q;
            end
         end
         assign rise[i] = sync_q & ~last_q;
      end
   endgenerate
endmodule
`default_nettype wire

// ===== logic/opc_pll.sv
`timescale 1ns/100ps
`default_nettype none
module opc_pll (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic enable,
   input wire logic src_tick,
   input wire logic [4:0] pre_sel,
   input wire logic [8:0] fb_sel,
   input wire logic [1:0] post_sel,
   output logic out_tick
);
   logic [5:0] n1;
   logic [9:0] m;
   logic [3:0] n2;
   logic [5:0] pre_cnt_q;
   logic vco_tick;
   logic [15:0] acc_q;

   // ---------------------------------------------------------------
   // Factor decode: prescale and feedback carry an offset of two
   // ---------------------------------------------------------------
   assign n1 = pre_sel + opc_pkg::N1_OFS;
   assign m = fb_sel + opc_pkg::M_OFS;
   // Reserved post code 2 is taken as divide by four
   always_comb begin
      case (post_sel)
         opc_pkg::POST_BY8: n2 = opc_pkg::N2_BY8;
         opc_pkg::POST_BY4, 2'h2: n2 = opc_pkg::N2_BY4;
         default: n2 = opc_pkg::N2_BY2;
      endcase
   end

   // Prescaler: one VCO input tick per n1 source ticks
   assign vco_tick = src_tick && (pre_cnt_q == n1 - 6'h01);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_cnt_q <= 6'h00;
      end else if (!enable) begin
         pre_cnt_q <= 6'h00;
      end else if (src_tick) begin
         pre_cnt_q <= vco_tick ? 6'h00 : pre_cnt_q + 6'h01;
      end
   end

   // Rate model: credit m per VCO tick, spend n2 per output tick.
   // Output is at most one tick per bus clock; excess credit saturates.
   assign out_tick = enable && (acc_q >= 16'(n2));
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_q <= 16'h0000;
      end else if (!enable) begin
         acc_q <= 16'h0000;
      end else begin
         acc_q <= acc_q + ((vco_tick && !acc_q[15]) ? 16'(m) : 16'h0000)
            - (out_tick ? 16'(n2) : 16'h0000);
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   pre_tick_a: assert property (@(posedge clk) disable iff (!rst_n)
      vco_tick |-> src_tick && pre_cnt_q == pre_sel + 6'h01)
      else $error("prescaler tick at wrong count");
   mult_credit_a: assert property (@(posedge clk) disable iff (!rst_n)
      enable && vco_tick && !out_tick && !acc_q[15] |=>
      acc_q == $past(acc_q) + 16'($past(fb_sel)) + 16'h0002)
      else $error("feedback credit not field plus two");
   post_map_a: assert property (@(posedge clk) disable iff (!rst_n)
      n2 == (post_sel == 2'h3 ? 4'h8 : post_sel == 2'h0 ? 4'h2 : 4'h4))
      else $error("postscale factor not 2, 4 or 8");
   out_spend_a: assert property (@(posedge clk) disable iff (!rst_n)
      enable && out_tick && !vco_tick |=> acc_q == $past(acc_q) - 16'($past(n2)))
      else $error("output tick did not spend postscale credit");
endmodule
`default_nettype wire

// ===== logic/opc_clock_select.sv
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module opc_clock_select (
   input wire logic pclk,
   input wire logic presetn,
   input wire opc_pkg::opc_apb_req_s apb_req,
   output opc_pkg::opc_apb_rsp_s apb_rsp,
   input wire logic [2:0] reset_source_select,
   input wire logic [1:0] primary_mode_select,
   input wire logic osc_pin_in,
   input wire logic xtal_amp_in,
   input wire logic sec_osc_in,
   output logic xtal_drive_en,
   output logic instruction_clock,
   output logic peripheral_clock,
   output logic slow_internal_rc
);
   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   opc_pkg::opc_div_s div_q;
   opc_pkg::opc_div_s div_act_q;
   logic [8:0] fbd_q;
   logic [8:0] fbd_act_q;
   logic [opc_pkg::TUNE_W-1:0] tune_q;
   opc_pkg::opc_src_e mode_q;
   opc_pkg::opc_pri_e pri_q;
   logic strap_done_q;
   logic [2:0] pin_rise;
   logic pri_tick;
   logic frc_tick_q;
   logic slow_tick;
   logic [opc_pkg::NCO_W-1:0] frc_acc_q;
   logic [opc_pkg::NCO_W-1:0] slow_acc_q;
   logic [opc_pkg::NCO_W-1:0] tune_ext;
   logic [opc_pkg::NCO_W-1:0] frc_inc;
   logic [opc_pkg::NCO_W:0] frc_sum;
   logic [opc_pkg::NCO_W:0] slow_sum;
   logic [2:0] frc_sel;
   logic [7:0] frc_last;
   logic [7:0] frc_cnt_q;
   logic frc_div_tick;
   logic pll_en;
   logic pll_src_tick;
   logic pll_tick;
   logic fosc_d;
   logic fosc_q;
   logic inst_q;
   logic peri_q;
   logic slow_q;
   logic xtal_q;
   logic setup;
   logic access;
   logic hit;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic [31:0] rd_val;
   opc_pkg::opc_stat_s stat;

   // ---------------------------------------------------------------
   // Pin inputs: every oscillator pin is synchronised first
   // ---------------------------------------------------------------
   opc_sync #(
      .W(3)
   ) u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .pin({sec_osc_in, xtal_amp_in, osc_pin_in}),
      .rise(pin_rise)
   );

   // ---------------------------------------------------------------
   // Configuration capture at reset release
   // ---------------------------------------------------------------
   // Erased-state defaults hold until the fields are caught once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= opc_pkg::SRC_FRC_DN;
         pri_q <= opc_pkg::PRI_NONE;
         strap_done_q <= 1'b0;
      end else if (!strap_done_q) begin
         mode_q <= opc_pkg::opc_src_e'(reset_source_select);
         pri_q <= opc_pkg::opc_pri_e'(primary_mode_select);
         strap_done_q <= 1'b1;
      end
   end

   // Crystal driver only runs for the two crystal modes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xtal_q <= 1'b0;
      end else begin
         xtal_q <= strap_done_q && (pri_q == opc_pkg::PRI_XTAL
            || pri_q == opc_pkg::PRI_HS);
      end
   end

   // External clock and unused codes read the pin with no driver
   assign pri_tick = xtal_q ? pin_rise[1] : pin_rise[0];

   // ---------------------------------------------------------------
   // Internal RC oscillator models
   // ---------------------------------------------------------------
   // Tuning is signed; wrap-around arithmetic gives the subtraction
   assign tune_ext = {{(opc_pkg::NCO_W - opc_pkg::TUNE_W){tune_q[opc_pkg::TUNE_W-1]}}, tune_q};
   assign frc_inc = opc_pkg::FRC_INC + opc_pkg::NCO_W'(tune_ext * opc_pkg::TUNE_STEP);
   assign frc_sum = {1'b0, frc_acc_q} + {1'b0, frc_inc};
   assign slow_sum = {1'b0, slow_acc_q} + {1'b0, opc_pkg::SLOW_INC};

   // Fast RC: carry of the phase accumulator is one oscillator tick
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frc_acc_q <= '0;
         frc_tick_q <= 1'b0;
      end else begin
         frc_acc_q <= frc_sum[opc_pkg::NCO_W-1:0];
         frc_tick_q <= frc_sum[opc_pkg::NCO_W];
      end
   end

   // Slow RC: free running; each carry toggles slow_internal_rc
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slow_acc_q <= '0;
         slow_q <= 1'b0;
      end else begin
         slow_acc_q <= slow_sum[opc_pkg::NCO_W-1:0];
         if (slow_sum[opc_pkg::NCO_W]) begin
            slow_q <= ~slow_q;
         end
      end
   end
   assign slow_tick = slow_sum[opc_pkg::NCO_W] && !slow_q;

   // ---------------------------------------------------------------
   // Fast RC postscaler
   // ---------------------------------------------------------------
   // Divide by two to the power of field plus one
   assign frc_sel = (mode_q == opc_pkg::SRC_FRC_D16) ? opc_pkg::FRC_DIV16_SEL
      : div_act_q.frc_post;
   assign frc_last = ~(8'hff << ({1'b0, frc_sel} + 4'h1));
   assign frc_div_tick = frc_tick_q && (frc_cnt_q == frc_last);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frc_cnt_q <= 8'h00;
      end else if (frc_tick_q) begin
         frc_cnt_q <= frc_div_tick ? 8'h00 : frc_cnt_q + 8'h01;
      end
   end

   // ---------------------------------------------------------------
   // PLL path
   // ---------------------------------------------------------------
   // Secondary and slow RC sources never reach the PLL
   assign pll_en = (mode_q == opc_pkg::SRC_FRC_PLL)
      || (mode_q == opc_pkg::SRC_PRI_PLL);
   assign pll_src_tick = (mode_q == opc_pkg::SRC_PRI_PLL) ? pri_tick : frc_tick_q;

   opc_pll u_pll (
      .clk(pclk),
      .rst_n(presetn),
      .enable(pll_en),
      .src_tick(pll_src_tick),
      .pre_sel(div_act_q.pll_pre),
      .fb_sel(fbd_act_q),
      .post_sel(div_act_q.pll_post),
      .out_tick(pll_tick)
   );

   // ---------------------------------------------------------------
   // Source multiplexer
   // ---------------------------------------------------------------
   // Tick streams only, so switching never cuts a clock phase short
   always_comb begin
      case (mode_q)
         opc_pkg::SRC_FRC: fosc_d = frc_tick_q;
         opc_pkg::SRC_FRC_PLL: fosc_d = pll_tick;
         opc_pkg::SRC_PRI: fosc_d = pri_tick;
         opc_pkg::SRC_PRI_PLL: fosc_d = pll_tick;
         opc_pkg::SRC_SEC: fosc_d = pin_rise[2];
         opc_pkg::SRC_SLOW: fosc_d = slow_tick;
         opc_pkg::SRC_FRC_D16: fosc_d = frc_div_tick;
         opc_pkg::SRC_FRC_DN: fosc_d = frc_div_tick;
         default: fosc_d = frc_tick_q;
      endcase
   end

   // ---------------------------------------------------------------
   // Derived clocks
   // ---------------------------------------------------------------
   // Each oscillator tick flips both clocks: frequency is half
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fosc_q <= 1'b0;
         inst_q <= 1'b0;
         peri_q <= 1'b0;
      end else begin
         fosc_q <= fosc_d;
         if (fosc_q) begin
            inst_q <= ~inst_q;
            peri_q <= ~peri_q;
         end
      end
   end

   // Active divider copies load only as the clock falls, so a write
   // mid-period cannot shorten a high or low phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_act_q <= opc_pkg::DIV_RST;
         fbd_act_q <= opc_pkg::FBD_RST;
      end else if (fosc_q && inst_q) begin
         div_act_q <= div_q;
         fbd_act_q <= fbd_q;
      end
   end

   // ---------------------------------------------------------------
   // APB slave: one wait-free access, errors on unmapped words
   // ---------------------------------------------------------------
   assign setup = apb_req.psel && !apb_req.penable;
   assign access = apb_req.psel && apb_req.penable && pready_q;
   assign hit = apb_req.paddr == opc_pkg::ADDR_DIV || apb_req.paddr == opc_pkg::ADDR_FBD
      || apb_req.paddr == opc_pkg::ADDR_TUNE || apb_req.paddr == opc_pkg::ADDR_STAT;

   assign stat = '{rsv: 9'h000, xtal_drive: xtal_q, pll_on: pll_en, pri: pri_q, src: mode_q};

   // Read mux; reserved bits and unmapped words read zero
   always_comb begin
      case (apb_req.paddr)
         opc_pkg::ADDR_DIV: rd_val = 32'(div_q);
         opc_pkg::ADDR_FBD: rd_val = 32'(fbd_q);
         opc_pkg::ADDR_TUNE: rd_val = 32'(tune_q);
         opc_pkg::ADDR_STAT: rd_val = 32'(stat);
         default: rd_val = 32'h0000_0000;
      endcase
   end

   // Answer registered in the setup cycle, shown for one access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= setup;
         pslverr_q <= setup && !hit;
         prdata_q <= (setup && !apb_req.pwrite) ? rd_val : 32'h0000_0000;
      end
   end

   // Writes land on the completing edge only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= opc_pkg::DIV_RST;
         fbd_q <= opc_pkg::FBD_RST;
         tune_q <= opc_pkg::TUNE_RST;
      end else if (access && apb_req.pwrite) begin
         case (apb_req.paddr)
            opc_pkg::ADDR_DIV: div_q <= opc_pkg::opc_div_s'(
               apb_req.pwdata[opc_pkg::REG_W-1:0] & 16'h07df);
            opc_pkg::ADDR_FBD: fbd_q <= apb_req.pwdata[8:0];
            opc_pkg::ADDR_TUNE: tune_q <= apb_req.pwdata[opc_pkg::TUNE_W-1:0];
            default: ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign apb_rsp = '{pready: pready_q, pslverr: pslverr_q, prdata: prdata_q};
   assign xtal_drive_en = xtal_q;
   assign instruction_clock = inst_q;
   assign peripheral_clock = peri_q;
   assign slow_internal_rc = slow_q;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   inst_toggle_a: assert property (@(posedge pclk) disable iff (!presetn)
      fosc_q |=> inst_q != $past(inst_q))
      else $error("instruction clock missed an oscillator tick");
   clock_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
      !fosc_q |=> $stable(inst_q) && inst_q == peri_q)
      else $error("derived clocks moved without a tick");
   frc_div_a: assert property (@(posedge pclk) disable iff (!presetn)
      frc_div_tick |-> frc_tick_q && frc_cnt_q == 8'((9'h002 << frc_sel) - 9'h001))
      else $error("fast RC postscaler count wrong");
   strap_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      strap_done_q |=> $stable(mode_q) && $stable(pri_q))
      else $error("source changed after capture");
   pll_bypass_a: assert property (@(posedge pclk) disable iff (!presetn)
      mode_q == opc_pkg::SRC_SEC || mode_q == opc_pkg::SRC_SLOW |-> !pll_en && !pll_tick
      && fosc_d == (mode_q == opc_pkg::SRC_SEC ? pin_rise[2] : slow_tick))
      else $error("PLL used for a bypass source");
   ext_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
      strap_done_q && pri_q == opc_pkg::PRI_EXT |=> !xtal_drive_en)
      else $error("crystal driver on in external clock mode");
   div_glitch_a: assert property (@(posedge pclk) disable iff (!presetn)
      !$stable(div_act_q) || !$stable(fbd_act_q) |-> $past(fosc_q) && $past(inst_q)
      && !inst_q)
      else $error("divider change away from clock fall");
endmodule
`default_nettype wire

// ===== tb/test_opc_clock_select.sv
`timescale 1ns/100ps
`default_nettype none
module test_opc_clock_select;
   // ---------------------------------------------------------------
   // Stimulus, design and pin oscillator
   // ---------------------------------------------------------------
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic osc = 1'b0;
   logic [2:0] src = 3'h0;
   logic [1:0] pri = 2'h0;
   logic xd, icl, pcl, slow, err;
   logic [31:0] rd;
   opc_pkg::opc_apb_req_s req = '0;
   opc_pkg::opc_apb_rsp_s rsp;
   int fail_count = 0;
   int tests_run = 0;
   int seed = 36;
   int cyc = 0;
   int pdiv = 0;

   opc_clock_select u_dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
      .reset_source_select(src), .primary_mode_select(pri), .osc_pin_in(osc),
      .xtal_amp_in(osc), .sec_osc_in(osc), .xtal_drive_en(xd), .instruction_clock(icl),
      .peripheral_clock(pcl), .slow_internal_rc(slow));

   always #50 pclk = ~pclk;

   // All pins share one 0.5 MHz source, so every pin mode has a known rate
   always @(posedge pclk) begin
      pdiv <= (pdiv == 9) ? 0 : pdiv + 1;
      if (pdiv == 9) osc <= ~osc;
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         fail_count++;
         final_report;
      end
   end

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic check(logic [31:0] got, logic [31:0] exp, string msg);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   // One APB transfer; held until pready is seen with penable.
   // No local limit: only the bench timeout ends a wait
   task automatic apb(logic wr, logic [11:0] a, logic [31:0] wd);
      @(posedge pclk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
      @(posedge pclk);
      req.penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask

   // Oscillator rate expected from mode, dividers and tuning
   function automatic real rate(int s, logic [15:0] d, logic [8:0] f, int t);
      real fast_internal_rc = 7.37e6 * (1.0 + t / 256.0);
      int n1 = d[4:0] + 2;
      int n2 = (d[7:6] == 2'h0) ? 2 : (d[7:6] == 2'h3) ? 8 : 4;
      int m = f + 2;
      case (s)
         0: return fast_internal_rc;
         1: return fast_internal_rc * m / (n1 * n2);
         3: return 5.0e5 * m / (n1 * n2);
         5: return 32768.0;
         6: return fast_internal_rc / 16.0;
         7: return fast_internal_rc / (2.0 ** (d[10:8] + 1));
         default: return 5.0e5;
      endcase
   endfunction

   // Toggle count over a window; tolerance covers the NCO models
   task automatic measure(int w, real hz);
      int t = 0;
      int s = 0;
      logic p = icl;
      logic q = slow;
      real e = hz * w / 1.0e7;
      repeat (w) begin
         @(posedge pclk);
         if (icl !== p) t++;
         if (slow === 1'b1 && q === 1'b0) s++;
         p = icl;
         q = slow;
         check(pcl, icl, "peripheral clock");
      end
      check(t >= e * 0.97 - 2 && t <= e * 1.03 + 2, 1, "clock rate");
      e = 32768.0 * w / 1.0e7;
      check(s >= e * 0.9 - 2 && s <= e * 1.1 + 2, 1, "slow rc rate");
   endtask

   task final_report;
      $display("tests run %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Every power-on mode in turn
   // ---------------------------------------------------------------
   initial begin
      logic [15:0] d;
      logic [8:0] f;
      for (int m = 0; m < 8; m++) begin
         src <= m[2:0];
         pri <= 2'($unsigned($random(seed)) % 3);
         presetn <= 1'b0;
         repeat (5) @(posedge pclk);
         presetn <= 1'b1;
         apb(0, 12'h00c, 0);
         check(rd[5:0], {m == 1 || m == 3, pri, m[2:0]}, "status");
         apb(0, 12'h000, 0);
         check(rd, 32'h0, "divisor reset");
         apb(0, 12'h004, 0);
         check(rd, 32'h1e, "feedback reset");
         if (m == 0) begin
            apb(1, 12'h000, 32'hffff);
            apb(0, 12'h000, 0);
            check(rd, 32'h07df, "divisor mask");
            apb(1, 12'h010, 32'h1);
            check(err, 1'b1, "unmapped write");
            apb(0, 12'h010, 0);
            check(err, 1'b1, "unmapped read error");
            check(rd, 32'h0, "unmapped read data");
            apb(1, 12'h00c, 32'hffff);
            apb(0, 12'h00c, 0);
            check(rd[5:0], {3'h0, pri, 3'h0}, "status read only");
            repeat (3) begin
               f = 9'($random(seed));
               apb(1, 12'h004, {23'h0, f});
               apb(0, 12'h004, 0);
               check(rd, {23'h0, f}, "feedback field");
            end
         end
         // Dividers per mode keep every PLL output below the bus clock
         d = (m == 1) ? 16'h00df : (m == 3) ? 16'h0040 : (m == 7) ? 16'h0200 : 16'h0;
         f = (m == 3) ? 9'h00e : 9'h01e;
         apb(1, 12'h000, {16'h0, d});
         apb(1, 12'h004, {23'h0, f});
         repeat (400) @(posedge pclk);
         measure(m == 5 ? 4000 : 2000, rate(m, d, f, 0));
         if (m == 2 || m == 3) check(xd, pri != 2'h0, "crystal drive");
         if (m == 0) begin
            apb(1, 12'h008, 32'h1f);
            repeat (50) @(posedge pclk);
            measure(2000, rate(0, d, f, 31));
            apb(1, 12'h008, 32'h20);
            repeat (50) @(posedge pclk);
            measure(2000, rate(0, d, f, -32));
         end
         $display("mode %0d done", m);
      end
      final_report;
   end
endmodule
`default_nettype wire
